// *** rtl/plc_pkg.sv ***
// Package with constants and types of the synthesizer lock and calibration
package plc_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_MHZ      = 200;
   localparam int LOCK_WIN_NS  = 5;
   localparam int LOCK_WIN_RAW = (LOCK_WIN_NS * CLK_MHZ) / 1000;
   localparam int LOCK_WIN_CYC = (LOCK_WIN_RAW < 1) ? 1 : LOCK_WIN_RAW;
   localparam int CAL_PERIODS  = 7;
   localparam int SETTLE_TICKS = 1;
   localparam int FINISH_TICKS = 1;
   localparam int BAND_BITS    = 5;
   localparam int BAND_COUNT   = 32;

   // ==========================================================
   // Register map
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

   localparam int CTRL_START  = 0;
   localparam int CTRL_ALG    = 1;
   localparam int CTRL_AUTO   = 2;
   localparam int CTRL_MUTE   = 3;
   localparam int CTRL_CP_LSB = 4;
   localparam int CP_BITS     = 3;
   localparam int CTRL_AMP_LSB = 8;
   localparam int AMP_BITS    = 2;
   localparam int CTRL_USED   = 10;

   localparam int STAT_LOCK     = 0;
   localparam int STAT_BUSY     = 1;
   localparam int STAT_BAND_LSB = 8;

   // ==========================================================
   // Calibration sequencer states
   typedef enum logic [1:0] {
      PLC_IDLE,
      PLC_SETTLE,
      PLC_SEARCH,
      PLC_FINISH
   } plc_cal_state_t;

endpackage

// *** rtl/plc_link_if.sv ***
// Interface joining the control top, lock detector and calibration sequencer
`timescale 1ns/1ps
interface plc_link_if;
   logic       pfd_up;
   logic       pfd_dn;
   logic       lock;
   logic       tick;
   logic       start;
   logic       alg;
   logic       auto_en;
   logic       vco_above;
   logic       busy;
   logic       done;
   logic [4:0] band;

   modport ctl (output pfd_up, output pfd_dn, output tick, output start,
                output alg, output auto_en, output vco_above,
                input lock, input busy, input done, input band);
   modport lk  (input pfd_up, input pfd_dn, output lock);
   modport seq (input tick, input start, input alg, input auto_en,
                input vco_above, input lock,
                output busy, output done, output band);
endinterface // plc_link_if

// *** rtl/plc_lock_det.sv ***
// Lock detector comparing rising edges of the up and down pulses
`timescale 1ns/1ps
module plc_lock_det (
   input wire logic pclk,
   input wire logic presetn,
   plc_link_if.lk   lk
);
   localparam int WIN = plc_pkg::LOCK_WIN_CYC;
   localparam int CW  = (WIN < 2) ? 1 : $clog2(WIN + 1);

   logic          up_d_r;
   logic          dn_d_r;
   logic          wait_r;
   logic          side_r;
   logic [CW-1:0] cnt_r;
   logic          lock_r;

   // ==========================================================
   // Edge pairing
   wire up_rise = lk.pfd_up & ~up_d_r;
   wire dn_rise = lk.pfd_dn & ~dn_d_r;
   wire other   = side_r ? up_rise : dn_rise;
   wire sep_ok  = (32'(cnt_r) + 1) < WIN;
   wire good    = (up_rise & dn_rise) | (wait_r & other & sep_ok);
   wire bad     = wait_r & ~sep_ok;
   wire single  = (up_rise ^ dn_rise) & ~wait_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_d_r <= 1'b0;
         dn_d_r <= 1'b0;
         wait_r <= 1'b0;
         side_r <= 1'b0;
         cnt_r  <= '0;
         lock_r <= 1'b0;
      end else begin
         up_d_r <= lk.pfd_up;
         dn_d_r <= lk.pfd_dn;
         wait_r <= single | (wait_r & ~good & ~bad);
         if (single) begin
            side_r <= dn_rise;
         end
         cnt_r  <= (single | ~wait_r) ? '0 : cnt_r + 1'b1;
         if (good) begin
            lock_r <= 1'b1;
         end else if (bad) begin
            lock_r <= 1'b0;
         end
      end
   end

   assign lk.lock = lock_r;
endmodule // plc_lock_det

// *** rtl/plc_cal_seq.sv ***
// Sub-band calibration sequencer stepping on the comparison tick
`timescale 1ns/1ps
module plc_cal_seq #(
   parameter int BAND_BITS = plc_pkg::BAND_BITS
) (
   input wire logic pclk,
   input wire logic presetn,
   plc_link_if.seq  sq
);
   initial begin
      if (BAND_BITS != plc_pkg::BAND_BITS) begin
         $error("Band width must match the 32 sub-bands");
      end
      if (plc_pkg::SETTLE_TICKS + BAND_BITS + plc_pkg::FINISH_TICKS
          != plc_pkg::CAL_PERIODS) begin
         $error("Calibration length mismatch");
      end
   end

   plc_pkg::plc_cal_state_t st_r;
   plc_pkg::plc_cal_state_t st_nxt;
   logic [BAND_BITS-1:0]    band_r;
   logic [2:0]              bit_r;
   logic                    pend_r;
   logic                    lock_t_r;
   logic                    done_r;

   // ==========================================================
   // Requests: software start or loss of lock seen on the tick
   wire lock_fall = sq.tick & lock_t_r & ~sq.lock;
   wire restart   = sq.auto_en & lock_fall;
   wire req       = sq.start | restart | pend_r;
   wire last_bit  = (bit_r == 3'd0);
   wire [BAND_BITS-1:0] probe = BAND_BITS'(1) << bit_r;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         plc_pkg::PLC_IDLE:   if (req & sq.tick) st_nxt = plc_pkg::PLC_SETTLE;
         plc_pkg::PLC_SETTLE: if (sq.tick) st_nxt = plc_pkg::PLC_SEARCH;
         plc_pkg::PLC_SEARCH:
            if (sq.tick & last_bit) st_nxt = plc_pkg::PLC_FINISH;
         plc_pkg::PLC_FINISH: if (sq.tick) st_nxt = plc_pkg::PLC_IDLE;
         default:             st_nxt = plc_pkg::PLC_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r     <= plc_pkg::PLC_IDLE;
         band_r   <= '0;
         bit_r    <= '0;
         pend_r   <= 1'b0;
         lock_t_r <= 1'b0;
         done_r   <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         done_r <= (st_r == plc_pkg::PLC_FINISH) & sq.tick;
         if (sq.tick) begin
            lock_t_r <= sq.lock;
         end
         // An idle tick serves every request seen with it, so the
         // flag clears there; a request while busy waits for idle
         if (st_r == plc_pkg::PLC_IDLE && sq.tick) begin
            pend_r <= 1'b0;
         end else if (sq.start | restart) begin
            pend_r <= 1'b1;
         end
         if (st_r == plc_pkg::PLC_SETTLE && sq.tick) begin
            band_r <= BAND_BITS'(1) << (BAND_BITS - 1);
            bit_r  <= 3'(BAND_BITS - 1);
         end
         if (st_r == plc_pkg::PLC_SEARCH && sq.tick) begin
            // Keep bit while the band still sits below target
            band_r <= (sq.vco_above ? band_r & ~probe : band_r)
                      | (last_bit ? '0 : probe >> 1);
            if (!last_bit) begin
               bit_r <= bit_r - 3'd1;
            end
         end
      end
   end

   assign sq.busy = (st_r != plc_pkg::PLC_IDLE);
   assign sq.done = done_r;
   assign sq.band = band_r;
endmodule // plc_cal_seq

// *** rtl/plc_top.sv ***
// Synthesizer lock detect, mute, pump and VCO calibration control
`timescale 1ns/1ps
module plc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        pfd_up,
   input  wire logic        pfd_dn,
   input  wire logic        comparison_rate,
   input  wire logic        vco_above,
   output logic             lock_detect,
   output logic             rf_out_en,
   output logic             lo_buf_en,
   output logic             mixer_en,
   output logic             if_amp_en,
   output logic             pump_en,
   output logic      [2:0]  pump_current_sel,
   output logic      [3:0]  pump_level,
   output logic             cal_voltage,
   output logic             cal_voltage_mid,
   output logic             cal_voltage_track,
   output logic      [4:0]  vco_band,
   output logic      [1:0]  vco_amp_sel
);
   plc_link_if lnk ();

   // ==========================================================
   // APB decode
   logic [plc_pkg::CTRL_USED-1:0] ctrl_r;
   logic [31:0]                   prdata_r;
   logic                          lock_r;
   logic                          rate_d_r;

   wire sel_ctrl = (paddr == plc_pkg::ADDR_CTRL);
   wire sel_stat = (paddr == plc_pkg::ADDR_STAT);
   wire mapped   = sel_ctrl | sel_stat;
   wire access   = psel & penable;
   wire wr_ctrl  = access & pwrite & sel_ctrl;
   // Read data is latched in setup so it stands through the access cycle
   wire rd_setup = psel & ~penable & ~pwrite;

   wire start_now  = ctrl_r[plc_pkg::CTRL_START];
   wire start_wr   = pwdata[plc_pkg::CTRL_START];
   wire cal_done   = lnk.done;
   // A write of one is a fresh request even in the done cycle
   wire start_req  = wr_ctrl & start_wr & (~start_now | cal_done);

   wire [31:0] ctrl_rd = {{(32 - plc_pkg::CTRL_USED){1'b0}}, ctrl_r};
   wire [31:0] stat_rd = ({27'h000_0000, lnk.band}
                          << plc_pkg::STAT_BAND_LSB)
                         | ({31'h0000_0000, lnk.busy}
                          << plc_pkg::STAT_BUSY)
                         | ({31'h0000_0000, lnk.lock}
                          << plc_pkg::STAT_LOCK);
   wire [31:0] rd_mux  = sel_ctrl ? ctrl_rd : (sel_stat ? stat_rd : '0);

   // ==========================================================
   // Control register; start bit self-clears, set wins
   logic [plc_pkg::CTRL_USED-1:0] ctrl_nxt;
   always_comb begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl) begin
         ctrl_nxt = pwdata[plc_pkg::CTRL_USED-1:0];
      end
      if (cal_done && !start_req) begin
         ctrl_nxt[plc_pkg::CTRL_START] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= plc_pkg::CTRL_RST[plc_pkg::CTRL_USED-1:0];
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (rd_setup) begin
         prdata_r <= rd_mux;
      end
   end

   // ==========================================================
   // Comparison tick: the divided reference arrives as a level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_d_r <= 1'b0;
      end else begin
         rate_d_r <= comparison_rate;
      end
   end

   assign lnk.tick      = comparison_rate & ~rate_d_r;
   assign lnk.pfd_up    = pfd_up;
   assign lnk.pfd_dn    = pfd_dn;
   assign lnk.start     = start_req;
   assign lnk.alg       = ctrl_r[plc_pkg::CTRL_ALG];
   assign lnk.auto_en   = ctrl_r[plc_pkg::CTRL_AUTO];
   assign lnk.vco_above = vco_above;

   plc_lock_det u_lock (
      .pclk    (pclk),
      .presetn (presetn),
      .lk      (lnk.lk)
   );

   plc_cal_seq #(
      .BAND_BITS (plc_pkg::BAND_BITS)
   ) u_seq (
      .pclk    (pclk),
      .presetn (presetn),
      .sq      (lnk.seq)
   );

   // ==========================================================
   // Analog control outputs, all from flip-flops
   logic       mute_r;
   logic       pump_en_r;
   logic       calv_r;
   logic [2:0] cp_r;
   logic [3:0] lvl_r;
   logic [1:0] amp_r;
   logic [4:0] band_r;
   logic       mid_r;
   logic       track_r;

   wire [2:0] cp_sel  = ctrl_r[plc_pkg::CTRL_CP_LSB +: plc_pkg::CP_BITS];
   wire [1:0] amp_sel = ctrl_r[plc_pkg::CTRL_AMP_LSB +: plc_pkg::AMP_BITS];
   wire       hold    = ctrl_r[plc_pkg::CTRL_MUTE] & ~lnk.lock;
   wire       alg1    = ctrl_r[plc_pkg::CTRL_ALG];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_r    <= 1'b0;
         mute_r    <= 1'b0;
         pump_en_r <= 1'b0;
         calv_r    <= 1'b0;
         cp_r      <= '0;
         lvl_r     <= '0;
         amp_r     <= '0;
         band_r    <= '0;
         mid_r     <= 1'b0;
         track_r   <= 1'b0;
      end else begin
         lock_r    <= lnk.lock;
         mute_r    <= hold;
         pump_en_r <= ~lnk.busy;
         calv_r    <= lnk.busy;
         cp_r      <= cp_sel;
         lvl_r     <= {1'b0, cp_sel} + 4'h1;
         amp_r     <= amp_sel;
         band_r    <= lnk.band;
         mid_r     <= ~alg1;
         track_r   <= alg1;
      end
   end

   // ==========================================================
   // Port drive; APB answers in the first access cycle
   assign prdata            = prdata_r;
   assign pready            = 1'b1;
   assign pslverr           = access & ~mapped;
   assign lock_detect       = lock_r;
   assign rf_out_en         = ~mute_r;
   assign lo_buf_en         = ~mute_r;
   assign mixer_en          = ~mute_r;
   assign if_amp_en         = ~mute_r;
   assign pump_en           = pump_en_r;
   assign pump_current_sel  = cp_r;
   assign pump_level        = lvl_r;
   assign cal_voltage       = calv_r;
   assign cal_voltage_mid   = mid_r;
   assign cal_voltage_track = track_r;
   assign vco_band          = band_r;
   assign vco_amp_sel       = amp_r;
endmodule // plc_top

// *** test/plc_top_properties.sv ***
// Checker of lock, mute, pump and calibration control at the top ports
`timescale 1ns/1ps
module plc_top_properties (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic        pslverr,
   input logic        pfd_up,
   input logic        pfd_dn,
   input logic        comparison_rate,
   input logic        lock_detect,
   input logic        rf_out_en,
   input logic        lo_buf_en,
   input logic        mixer_en,
   input logic        if_amp_en,
   input logic        pump_en,
   input logic [2:0]  pump_current_sel,
   input logic [3:0]  pump_level,
   input logic        cal_voltage,
   input logic        cal_voltage_mid,
   input logic        cal_voltage_track,
   input logic [1:0]  vco_amp_sel
);
   // ==========================================================
   // Helper logic
   logic [1:0] up_r;
   logic       mute_r;
   logic       cr_r;
   logic [3:0] tk_r;
   wire        acc  = psel && penable;
   wire        wr_c = acc && pwrite && (paddr == plc_pkg::ADDR_CTRL);
   wire        ok   = up_r[1];
   wire        en   = rf_out_en;
   // Ticks counted on the raw comparison clock while calibrating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_r   <= 2'h0;
         mute_r <= 1'b0;
         cr_r   <= 1'b0;
         tk_r   <= 4'h0;
      end else begin
         up_r <= {up_r[0], 1'b1};
         cr_r <= comparison_rate;
         if (wr_c) mute_r <= pwdata[3];
         if (!cal_voltage) tk_r <= 4'h0;
         else if (comparison_rate && !cr_r) tk_r <= tk_r + 4'h1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Properties
   chk_bad_addr: assert property (acc |-> pslverr ==
      (paddr != plc_pkg::ADDR_CTRL && paddr != plc_pkg::ADDR_STAT))
      else $error("pslverr wrong for address");
   chk_pump_step: assert property (ok |->
      pump_level == {1'b0, pump_current_sel} + 4'h1)
      else $error("pump level not select plus one");
   chk_amp_follow: assert property (wr_c |->
      ##2 vco_amp_sel == $past(pwdata[9:8], 2))
      else $error("amplitude select not taken");
   chk_alg_follow: assert property (wr_c |-> ##2
      cal_voltage_track == $past(pwdata[1], 2) &&
      cal_voltage_mid != cal_voltage_track)
      else $error("calibration voltage mode wrong");
   chk_mute_gate: assert property (ok && $stable(mute_r) |->
      en == !(mute_r && !lock_detect) && lo_buf_en == en &&
      mixer_en == en && if_amp_en == en)
      else $error("output paths not gated by lock");
   chk_lock_pair: assert property ($rose(pfd_up) && $rose(pfd_dn)
      |-> ##2 lock_detect)
      else $error("lock not set by paired edges");
   chk_lock_lone: assert property ($rose(pfd_up) != $rose(pfd_dn)
      |-> ##3 !lock_detect)
      else $error("lock kept after lone edge");
   chk_pump_off: assert property (cal_voltage |-> !pump_en)
      else $error("pump on during calibration");
   chk_start_run: assert property (wr_c && pwdata[0] && !cal_voltage
      |-> ##[1:240] cal_voltage)
      else $error("calibration did not start");
   chk_seven_ticks: assert property ($fell(cal_voltage) |->
      tk_r == 4'h7)
      else $error("calibration length not seven ticks");
   chk_pump_back: assert property ($fell(cal_voltage) |->
      ##[0:2] pump_en)
      else $error("pump not enabled after calibration");
   cov_start: cover property (wr_c && pwdata[0]);
   cov_done: cover property ($fell(cal_voltage));
   cov_lock: cover property ($rose(lock_detect));
endmodule // plc_top_properties

bind plc_top plc_top_properties u_plc_top_properties (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .pfd_up(pfd_up), .pfd_dn(pfd_dn), .comparison_rate(comparison_rate),
   .lock_detect(lock_detect), .rf_out_en(rf_out_en),
   .lo_buf_en(lo_buf_en), .mixer_en(mixer_en), .if_amp_en(if_amp_en),
   .pump_en(pump_en), .pump_current_sel(pump_current_sel),
   .pump_level(pump_level), .cal_voltage(cal_voltage),
   .cal_voltage_mid(cal_voltage_mid),
   .cal_voltage_track(cal_voltage_track), .vco_amp_sel(vco_amp_sel));

// *** test/plc_top_tb_top.sv ***
// Self-checking bench of lock, mute, pump and calibration control
`timescale 1ns/1ps
module plc_top_tb_top;
   localparam logic [11:0] A_C = plc_pkg::ADDR_CTRL;
   localparam logic [11:0] A_S = plc_pkg::ADDR_STAT;
   logic        pclk;
   logic        presetn         = 1'b0;
   logic        psel            = 1'b0;
   logic        penable         = 1'b0;
   logic        pwrite          = 1'b0;
   logic [11:0] paddr           = 12'h000;
   logic [31:0] pwdata          = 32'h0000_0000;
   logic        pfd_up          = 1'b0;
   logic        pfd_dn          = 1'b0;
   logic        comparison_rate = 1'b0;
   logic        vco_above       = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        lock_detect;
   logic        rf_out_en;
   logic        lo_buf_en;
   logic        mixer_en;
   logic        if_amp_en;
   logic        pump_en;
   logic [2:0]  pump_current_sel;
   logic [3:0]  pump_level;
   logic        cal_voltage;
   logic        cal_voltage_mid;
   logic        cal_voltage_track;
   logic [4:0]  vco_band;
   logic [1:0]  vco_amp_sel;
   logic [4:0]  tgt = 5'h00;
   logic [31:0] rd;
   logic        err;
   int          bad_count = 0;
   int          compares  = 0;
   int          cyc       = 0;

   plc_top u_plc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pfd_up(pfd_up), .pfd_dn(pfd_dn), .comparison_rate(comparison_rate),
      .vco_above(vco_above), .lock_detect(lock_detect),
      .rf_out_en(rf_out_en), .lo_buf_en(lo_buf_en), .mixer_en(mixer_en),
      .if_amp_en(if_amp_en), .pump_en(pump_en),
      .pump_current_sel(pump_current_sel), .pump_level(pump_level),
      .cal_voltage(cal_voltage), .cal_voltage_mid(cal_voltage_mid),
      .cal_voltage_track(cal_voltage_track), .vco_band(vco_band),
      .vco_amp_sel(vco_amp_sel));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // ==========================================================
   // Comparison clock, comparator and timeout
   // Period of 210 cycles keeps the rate just under 1 MHz
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      // Dividers stay fixed, so no reprogram step follows calibration
      if (cyc % 105 == 104) comparison_rate <= !comparison_rate;
      vco_above <= (vco_band > tgt);
      if (cyc == 20000) begin
         bad_count++;
         final_report;
      end
   end
   // ==========================================================
   // Tasks
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Read data and error are taken at the edge that completes the access
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      err = pslverr;
      rd  = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pfd(input logic u, input logic d);
      @(posedge pclk);
      pfd_up <= u;
      pfd_dn <= d;
      @(posedge pclk);
      pfd_up <= 1'b0;
      pfd_dn <= 1'b0;
      repeat (4) @(posedge pclk);
      #1;
   endtask
   task automatic cal(input logic [4:0] t, input logic a);
      tgt = t;
      apb(1'b1, A_C, {30'h0, a, 1'b1});
      repeat (300) if (cal_voltage !== 1'b1) @(posedge pclk);
      #1 check(pump_en, 1'b0);
      check(cal_voltage_mid, !a);
      check(cal_voltage_track, a);
      apb(1'b0, A_C, 32'h0);
      check(rd, {30'h0, a, 1'b1});
      apb(1'b0, A_S, 32'h0);
      check(rd[1], 1'b1);
      repeat (2000) if (cal_voltage !== 1'b0) @(posedge pclk);
      repeat (3) @(posedge pclk);
      #1 check(vco_band, t);
      check(pump_en, 1'b1);
      apb(1'b0, A_C, 32'h0);
      check(rd, {30'h0, a, 1'b0});
      apb(1'b0, A_S, 32'h0);
      check(rd[12:8], t);
   endtask
   task automatic final_report;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, A_C, 32'h0);
      check(rd, plc_pkg::CTRL_RST);
      apb(1'b0, A_S, 32'h0);
      check(rd, 32'h0);
      check(pump_level, 4'h1);
      apb(1'b0, 12'h008, 32'h0);
      check({rd[30:0], err}, 32'h1);
      apb(1'b1, 12'h00C, 32'h0000_0370);
      apb(1'b1, A_C, 32'hFFFF_FC00);
      apb(1'b1, A_S, 32'h0000_1F02);
      apb(1'b0, A_S, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, A_C, 32'h0);
      check(rd, 32'h0);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, A_C, (32'(i) << 4) | ((32'(i) & 32'h3) << 8));
         repeat (2) @(posedge pclk);
         #1 check(pump_level, 32'(i + 1));
         check(pump_current_sel, 32'(i));
         check(vco_amp_sel, 32'(i % 4));
      end
      apb(1'b1, A_C, 32'h0000_0008);
      repeat (3) @(posedge pclk);
      #1 check({rf_out_en, lo_buf_en, mixer_en, if_amp_en}, 4'h0);
      pfd(1'b1, 1'b1);
      check(lock_detect, 1'b1);
      check({rf_out_en, lo_buf_en, mixer_en, if_amp_en}, 4'hF);
      pfd(1'b1, 1'b0);
      check(lock_detect, 1'b0);
      check(rf_out_en, 1'b0);
      cal(5'd13, 1'b0);
      cal(5'd31, 1'b1);
      cal(5'd0, 1'b0);
      // Lock is held over two ticks, then lost with no start request
      pfd(1'b1, 1'b1);
      tgt = 5'd7;
      apb(1'b1, A_C, 32'h0000_0004);
      repeat (450) @(posedge pclk);
      pfd(1'b1, 1'b0);
      repeat (600) if (cal_voltage !== 1'b1) @(posedge pclk);
      #1 check(cal_voltage, 1'b1);
      repeat (2000) if (cal_voltage !== 1'b0) @(posedge pclk);
      repeat (3) @(posedge pclk);
      #1 check(vco_band, 5'd7);
      repeat (300) @(posedge pclk);
      #1 check(cal_voltage, 1'b0);
      final_report;
   end
endmodule // plc_top_tb_top
